// >>> vmcc_top.sv
// vmcc_top: voltage-mode chopper configuration, regulation and bridge control
// assumes: avalon-mm master on the same clock; pins spread and comparator are asynchronous
`timescale 1ns/10ps
`default_nettype none
module vmcc_top
  import vmcc_pkg::*;
#(
  parameter int STANDBY_TICK = VMCC_STANDBY_TICK
)(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        clk_en,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        spread_pin,
  input  wire logic        current_low_pin,
  input  wire logic [19:0] microstep_interval,
  input  wire logic        fullstep_strobe,
  input  wire logic        motor_standstill,
  input  wire logic [4:0]  run_current,
  output logic             coil_a_high,
  output logic             coil_a_low,
  output logic             coil_b_high,
  output logic             coil_b_low,
  output logic             voltage_mode_active,
  output logic             comparator_masked,
  output logic [7:0]       pwm_amplitude
);
  if (STANDBY_TICK < 2 || STANDBY_TICK > 32'h00ffffff) begin : g_chk
    $error("vmcc_top: STANDBY_TICK out of range");
  end

  function automatic logic [7:0] sat8(input logic [9:0] v);
    return (v > 10'd255) ? 8'hff : v[7:0];
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] pin_in, sync1_reg, sync2_reg;
  assign pin_in = {current_low_pin, spread_pin};
  for (genvar i = 0; i < 2; i++) begin : g_sync
    always_ff @(posedge clock) begin
      if (rst) begin
        sync1_reg[i] <= 1'b0;
        sync2_reg[i] <= 1'b0;
      end else if (clk_en) begin
        sync1_reg[i] <= pin_in[i];
        sync2_reg[i] <= sync1_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // register file and bus slave
  // ----------------------------------------------------------------
  logic [31:0] gcfg_reg, gcfg_next, vlim_reg, vlim_next, ampl_reg, ampl_next;
  logic [31:0] drv_reg, drv_next, stby_reg, stby_next, rdata_next, status;
  logic        wait_reg, wait_next, take;
  logic [7:0]  corr_reg, tofs_reg, tgrad_reg;
  logic        standing;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be, input logic [31:0] mask);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) if (be[b]) r[b*8 +: 8] = wd[b*8 +: 8];
    return r & mask;
  endfunction

  assign take = (avs_read || avs_write) && !wait_reg;
  assign status = {6'h00, standing, voltage_mode_active, tgrad_reg, tofs_reg, corr_reg};

  always_comb begin
    gcfg_next  = gcfg_reg;
    vlim_next  = vlim_reg;
    ampl_next  = ampl_reg;
    drv_next   = drv_reg;
    stby_next  = stby_reg;
    wait_next  = !((avs_read || avs_write) && wait_reg);
    rdata_next = avs_readdata;
    if (avs_read && wait_reg) begin
      case (avs_address)
        VMCC_OFS_GLOBAL:  rdata_next = gcfg_reg;
        VMCC_OFS_VELLIM:  rdata_next = vlim_reg;
        VMCC_OFS_AMPL:    rdata_next = ampl_reg;
        VMCC_OFS_DRIVER:  rdata_next = drv_reg;
        VMCC_OFS_STANDBY: rdata_next = stby_reg;
        VMCC_OFS_STATUS:  rdata_next = status;
        default:          rdata_next = 32'h0000_0000;
      endcase
    end
    if (take && avs_write) begin
      case (avs_address)
        VMCC_OFS_GLOBAL:  gcfg_next = merge(gcfg_reg, avs_writedata, avs_byteenable, 32'h0000_fff7);
        VMCC_OFS_VELLIM:  vlim_next = merge(vlim_reg, avs_writedata, avs_byteenable, 32'h000f_ffff);
        VMCC_OFS_AMPL:    ampl_next = merge(ampl_reg, avs_writedata, avs_byteenable, 32'h0000_ffff);
        VMCC_OFS_DRIVER:  drv_next  = merge(drv_reg, avs_writedata, avs_byteenable, 32'h0000_1f3f);
        VMCC_OFS_STANDBY: stby_next = merge(stby_reg, avs_writedata, avs_byteenable, 32'h0000_0fff);
        default:          ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      gcfg_reg <= {16'h0000, VMCC_RST_REGCOEF, VMCC_RST_LIMIT, 8'h00};
      vlim_reg <= 32'h0000_0000;
      ampl_reg <= {16'h0000, VMCC_RST_GRAD, VMCC_RST_OFS};
      drv_reg  <= {26'h0000000, VMCC_RST_BLANK, 4'h0};
      stby_reg <= 32'h0000_0000;
      wait_reg <= 1'b1;
      avs_readdata <= 32'h0000_0000;
    end else if (clk_en) begin
      gcfg_reg <= gcfg_next;
      vlim_reg <= vlim_next;
      ampl_reg <= ampl_next;
      drv_reg  <= drv_next;
      stby_reg <= stby_next;
      wait_reg <= wait_next;
      avs_readdata <= rdata_next;
    end
  end
  assign avs_waitrequest = wait_reg;

  // field views
  logic       f_dis, f_auto, f_agrad;
  logic [1:0] f_rate, f_opt, f_blank;
  logic [3:0] f_lim, f_coef, f_off_time, f_hrd;
  logic [7:0] f_ofs, f_grad, f_pdd;
  logic [4:0] f_hold;
  assign f_dis   = gcfg_reg[VMCC_B_DISABLE];
  assign f_auto  = gcfg_reg[VMCC_B_AUTOSCALE];
  assign f_agrad = gcfg_reg[VMCC_B_AUTOGRAD];
  assign f_rate  = gcfg_reg[VMCC_F_RATE +: 2];
  assign f_opt   = gcfg_reg[VMCC_F_STANDOPT +: 2];
  assign f_lim   = gcfg_reg[VMCC_F_LIMIT +: 4];
  assign f_coef  = gcfg_reg[VMCC_F_REGCOEF +: 4];
  assign f_ofs   = ampl_reg[7:0];
  assign f_grad  = ampl_reg[VMCC_F_GRAD +: 8];
  assign f_off_time  = drv_reg[VMCC_F_OFFTIME +: 4];
  assign f_blank = drv_reg[VMCC_F_BLANK +: 2];
  assign f_hold  = drv_reg[VMCC_F_HOLDCUR +: 5];
  assign f_pdd   = stby_reg[VMCC_F_PDDELAY +: 8];
  assign f_hrd   = stby_reg[VMCC_F_HRDELAY +: 4];

  // ----------------------------------------------------------------
  // mode selection and standstill sequencing
  // ----------------------------------------------------------------
  logic       eff_dis, drv_on, vmode_now, limit_reg, limit_next;
  vmcc_ss_t   ss_reg, ss_next;
  logic [24:0] pre_reg, pre_next;
  logic [8:0]  tick_cnt_reg, tick_cnt_next;
  assign eff_dis   = f_dis ^ sync2_reg[0];
  assign drv_on    = (f_off_time != 4'h0);
  assign vmode_now = !eff_dis && drv_on && (microstep_interval >= vlim_reg[19:0]);
  assign standing  = (ss_reg == VMCC_SS_HOLD);

  always_comb begin
    ss_next       = ss_reg;
    pre_next      = pre_reg;
    tick_cnt_next = tick_cnt_reg;
    // re-entry from current mode starts a limited window until the next fullstep
    limit_next    = (vmode_now && !voltage_mode_active) || (limit_reg && !fullstep_strobe);
    case (ss_reg)
      VMCC_SS_RUN: begin
        pre_next      = 25'd0;
        tick_cnt_next = 9'd0;
        if (motor_standstill && f_hold == 5'd0 && vmode_now) ss_next = VMCC_SS_WAIT;
      end
      VMCC_SS_WAIT: begin
        if (!motor_standstill || f_hold != 5'd0 || !vmode_now) ss_next = VMCC_SS_RUN;
        else if (tick_cnt_reg >= {1'b0, f_pdd} + {5'h00, f_hrd}) ss_next = VMCC_SS_HOLD;
        else if (pre_reg >= 25'(STANDBY_TICK - 1)) begin
          pre_next      = 25'd0;
          tick_cnt_next = tick_cnt_reg + 9'd1;
        end else pre_next = pre_reg + 25'd1;
      end
      VMCC_SS_HOLD: begin
        if (!motor_standstill || f_hold != 5'd0 || !vmode_now) ss_next = VMCC_SS_RUN;
      end
      default: ss_next = VMCC_SS_RUN;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      ss_reg       <= VMCC_SS_RUN;
      pre_reg      <= 25'd0;
      tick_cnt_reg <= 9'd0;
      limit_reg    <= 1'b0;
    end else if (clk_en) begin
      ss_reg       <= ss_next;
      pre_reg      <= pre_next;
      tick_cnt_reg <= tick_cnt_next;
      limit_reg    <= limit_next;
    end
  end

  // ----------------------------------------------------------------
  // amplitude regulation and tuning
  // ----------------------------------------------------------------
  logic [8:0]  corr2_reg, corr2_next;
  logic [7:0]  tofs_next, tgrad_next, corr_next, ofs_term, grad_use, amp_ff, amp_sel, cap;
  logic [12:0] ofs_prod;
  logic [7:0]  amp_next;
  logic        cur_low;
  assign cur_low = sync2_reg[1];

  always_comb begin
    corr2_next = corr2_reg;
    tofs_next  = tofs_reg;
    tgrad_next = tgrad_reg;
    if (!f_auto || !voltage_mode_active) begin
      if (!f_auto) begin
        tofs_next  = f_ofs;
        tgrad_next = f_grad;
      end
    end else if (fullstep_strobe && !standing) begin
      // gain in half steps: coefficient n adds n/2 per fullstep
      if (cur_low) corr2_next = (corr2_reg > 9'h1ff - {5'h00, f_coef}) ? 9'h1ff
                                : corr2_reg + {5'h00, f_coef};
      else corr2_next = (corr2_reg < {5'h00, f_coef}) ? 9'h000
                        : corr2_reg - {5'h00, f_coef};
      if (motor_standstill) tofs_next = cur_low ? sat8({2'b00, tofs_reg} + 10'd1)
                                        : ((tofs_reg == 8'h00) ? 8'h00 : tofs_reg - 8'h01);
      else if (f_agrad) tgrad_next = cur_low ? sat8({2'b00, tgrad_reg} + 10'd1)
                                     : ((tgrad_reg == 8'h00) ? 8'h00 : tgrad_reg - 8'h01);
    end
    corr_next = corr2_next[8:1];
    ofs_prod  = {5'h00, (f_auto ? tofs_reg : f_ofs)} * {8'h00, run_current} + 13'h0000;
    ofs_term  = (f_ofs == 8'h00) ? 8'h00 : ofs_prod[12:5];
    grad_use  = (f_auto && f_agrad) ? tgrad_reg : f_grad;
    amp_ff    = sat8({2'b00, ofs_term} + {2'b00, grad_use});
    amp_sel   = f_auto ? sat8({2'b00, amp_ff} + {2'b00, corr_reg}) : amp_ff;
    cap       = {f_lim, 4'h0};
    amp_next  = (limit_reg && amp_sel > cap) ? cap : amp_sel;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      corr2_reg     <= 9'd0;
      corr_reg      <= 8'h00;
      tofs_reg      <= VMCC_RST_OFS;
      tgrad_reg     <= VMCC_RST_GRAD;
      pwm_amplitude <= 8'h00;
    end else if (clk_en) begin
      corr2_reg     <= corr2_next;
      corr_reg      <= corr_next;
      tofs_reg      <= tofs_next;
      tgrad_reg     <= tgrad_next;
      pwm_amplitude <= amp_next;
    end
  end

  // ----------------------------------------------------------------
  // pwm, blanking and bridge outputs
  // ----------------------------------------------------------------
  logic pwm_level, blank_int;
  logic [3:0] bridge_next;

  vmcc_pwm_timebase u_pwm (
    .clock     (clock),
    .rst       (rst),
    .clk_en    (clk_en),
    .rate_sel  (f_rate),
    .amplitude (pwm_amplitude),
    .pwm_level (pwm_level),
    .pwm_tick  ()
  );

  vmcc_blank_timer u_blank (
    .clock        (clock),
    .rst          (rst),
    .clk_en       (clk_en),
    .blank_sel    (f_blank),
    .switch_event (pwm_level != coil_a_high && voltage_mode_active),
    .masked       (blank_int)
  );

  always_comb begin
    // order: a_high, a_low, b_high, b_low
    if (!drv_on || !voltage_mode_active) bridge_next = 4'h0;
    else if (standing) begin
      case (vmcc_opt_t'(f_opt))
        VMCC_OPT_FREE:    bridge_next = 4'h0;
        VMCC_OPT_LOWSHT:  bridge_next = 4'h5;
        VMCC_OPT_HIGHSHT: bridge_next = 4'ha;
        default:          bridge_next = {pwm_level, !pwm_level, pwm_level, !pwm_level};
      endcase
    end else bridge_next = {pwm_level, !pwm_level, pwm_level, !pwm_level};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      {coil_a_high, coil_a_low, coil_b_high, coil_b_low} <= 4'h0;
      voltage_mode_active <= 1'b0;
      comparator_masked   <= 1'b0;
    end else if (clk_en) begin
      {coil_a_high, coil_a_low, coil_b_high, coil_b_low} <= bridge_next;
      voltage_mode_active <= vmode_now;
      comparator_masked   <= blank_int;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence s_req_wait; clk_en && (avs_read || avs_write) && avs_waitrequest; endsequence
  a_bus_answer_one: assert property (s_req_wait |=> !avs_waitrequest || !clk_en)
    else $error("bus request not answered in one cycle");
  a_disable_xor: assert property (clk_en && (f_dis ^ sync2_reg[0]) |=> !voltage_mode_active)
    else $error("voltage mode active while disabled");
  a_velocity_stop: assert property (clk_en && microstep_interval < vlim_reg[19:0]
    |=> !voltage_mode_active)
    else $error("voltage mode kept above velocity limit");
  a_limit_cap: assert property (clk_en && limit_reg && amp_sel > {f_lim, 4'h0}
    |=> pwm_amplitude == $past(cap))
    else $error("amplitude not capped on re-entry");
  a_driver_off: assert property (clk_en && f_off_time == 4'h0 ##1 clk_en
    |=> !coil_a_high && !coil_a_low && !coil_b_high && !coil_b_low)
    else $error("bridge driven with zero off time");
  a_corr_frozen: assert property (clk_en && !voltage_mode_active |=> $stable(corr_reg))
    else $error("correction moved in current mode");
  a_manual_seed: assert property (clk_en && !f_auto |=> tofs_reg == $past(f_ofs))
    else $error("tuned offset not seeded from user offset");
  a_hold_wait: assert property (clk_en && ss_reg == VMCC_SS_RUN |=> ss_reg != VMCC_SS_HOLD)
    else $error("standstill option applied without delay");
  a_standstill_option: assert property (clk_en && standing && f_opt == 2'h1 && drv_on
    && voltage_mode_active |=> !coil_a_high && !coil_a_low)
    else $error("standstill_option option drives the bridge");
  a_blank_len: assert property (clk_en && u_blank.switch_event && f_blank == 2'h0
    |=> u_blank.cnt_reg == VMCC_BLANK0 || !clk_en)
    else $error("blank time not loaded");
endmodule // vmcc_top
`default_nettype wire

// >>> vmcc_pkg.sv
// vmcc_pkg: register map, field layout, reset values and timing counts of the chopper config block
// assumes: one 100 MHz clock, 32-bit avalon-mm slave with byte addresses
package vmcc_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] VMCC_OFS_GLOBAL   = 5'h00;
  localparam logic [4:0] VMCC_OFS_VELLIM   = 5'h04;
  localparam logic [4:0] VMCC_OFS_AMPL     = 5'h08;
  localparam logic [4:0] VMCC_OFS_DRIVER   = 5'h0c;
  localparam logic [4:0] VMCC_OFS_STANDBY  = 5'h10;
  localparam logic [4:0] VMCC_OFS_STATUS   = 5'h14;

  // ----------------------------------------------------------------
  // global_config field positions
  // ----------------------------------------------------------------
  localparam int VMCC_B_DISABLE   = 0;
  localparam int VMCC_B_AUTOSCALE = 1;
  localparam int VMCC_B_AUTOGRAD  = 2;
  localparam int VMCC_F_RATE      = 4;
  localparam int VMCC_F_STANDOPT  = 6;
  localparam int VMCC_F_LIMIT     = 8;
  localparam int VMCC_F_REGCOEF   = 12;
  // driver, standby and amplitude gradient fields
  localparam int VMCC_F_OFFTIME   = 0;
  localparam int VMCC_F_BLANK     = 4;
  localparam int VMCC_F_HOLDCUR   = 8;
  localparam int VMCC_F_PDDELAY   = 0;
  localparam int VMCC_F_HRDELAY   = 8;
  localparam int VMCC_F_GRAD      = 8;
  // status fields
  localparam int VMCC_F_ST_OFS    = 8;
  localparam int VMCC_F_ST_GRAD   = 16;
  localparam int VMCC_B_ST_VMODE  = 24;
  localparam int VMCC_B_ST_STAND  = 25;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [3:0] VMCC_RST_LIMIT   = 4'hc;
  localparam logic [3:0] VMCC_RST_REGCOEF = 4'h4;
  localparam logic [7:0] VMCC_RST_OFS     = 8'h1e;
  localparam logic [7:0] VMCC_RST_GRAD    = 8'h00;
  localparam logic [1:0] VMCC_RST_BLANK   = 2'h1;

  // ----------------------------------------------------------------
  // timing: pwm periods in clocks, f_pwm = 2/period, and blank times
  // ----------------------------------------------------------------
  localparam logic [10:0] VMCC_PER0 = 11'd1024;
  localparam logic [10:0] VMCC_PER1 = 11'd683;
  localparam logic [10:0] VMCC_PER2 = 11'd512;
  localparam logic [10:0] VMCC_PER3 = 11'd410;
  localparam logic [5:0]  VMCC_BLANK0 = 6'd16;
  localparam logic [5:0]  VMCC_BLANK1 = 6'd24;
  localparam logic [5:0]  VMCC_BLANK2 = 6'd36;
  localparam logic [5:0]  VMCC_BLANK3 = 6'd54;
  localparam int VMCC_CLK_MHZ         = 100;
  localparam int VMCC_STANDBY_TICK_US = 2621;
  localparam int VMCC_STANDBY_TICK    = VMCC_STANDBY_TICK_US * VMCC_CLK_MHZ;

  typedef enum logic [1:0] {
    VMCC_SS_RUN  = 2'b00,
    VMCC_SS_WAIT = 2'b01,
    VMCC_SS_HOLD = 2'b11
  } vmcc_ss_t;

  typedef enum logic [1:0] {
    VMCC_OPT_NORMAL = 2'h0,
    VMCC_OPT_FREE   = 2'h1,
    VMCC_OPT_LOWSHT = 2'h2,
    VMCC_OPT_HIGHSHT = 2'h3
  } vmcc_opt_t;

endpackage

// >>> vmcc_pwm_timebase.sv
// vmcc_pwm_timebase: triangle counter for the voltage pwm and its comparator
// assumes: same clock and clock enable as the parent; amplitude is registered
`timescale 1ns/10ps
`default_nettype none
module vmcc_pwm_timebase
  import vmcc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic [1:0] rate_sel,
  input  wire logic [7:0] amplitude,
  output logic            pwm_level,
  output logic            pwm_tick
);
  logic [10:0] cnt_reg, cnt_next, period, half, tri_val;
  logic [18:0] thresh;

  // one pwm_level period spans a whole count, so pwm_level runs at half f_pwm
  always_comb begin
    case (rate_sel)
      2'h0:    period = VMCC_PER0;
      2'h1:    period = VMCC_PER1;
      2'h2:    period = VMCC_PER2;
      default: period = VMCC_PER3;
    endcase
    half     = period >> 1;
    cnt_next = (cnt_reg >= period - 11'd1) ? 11'd0 : cnt_reg + 11'd1;
    tri_val  = (cnt_reg < half) ? cnt_reg : period - 11'd1 - cnt_reg;
    thresh   = 19'({8'h00, amplitude} * {8'h00, half}) >> 8;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      cnt_reg   <= 11'd0;
      pwm_level <= 1'b0;
      pwm_tick  <= 1'b0;
    end else if (clk_en) begin
      cnt_reg   <= cnt_next;
      pwm_level <= ({8'h00, tri_val} < thresh);
      pwm_tick  <= (cnt_reg == 11'd0) || (cnt_reg == half);
    end
  end
endmodule // vmcc_pwm_timebase
`default_nettype wire

// >>> vmcc_blank_timer.sv
// vmcc_blank_timer: masks the current comparator after each switching event
// assumes: event is a one-cycle pulse in the parent's clock domain
`timescale 1ns/10ps
`default_nettype none
module vmcc_blank_timer
  import vmcc_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       clk_en,
  input  wire logic [1:0] blank_sel,
  input  wire logic       switch_event,
  output logic            masked
);
  logic [5:0] cnt_reg, cnt_next, load;

  always_comb begin
    case (blank_sel)
      2'h0:    load = VMCC_BLANK0;
      2'h1:    load = VMCC_BLANK1;
      2'h2:    load = VMCC_BLANK2;
      default: load = VMCC_BLANK3;
    endcase
    if (switch_event) cnt_next = load;
    else if (cnt_reg != 6'd0) cnt_next = cnt_reg - 6'd1;
    else cnt_next = cnt_reg;
  end

  always_ff @(posedge clock) begin
    if (rst) cnt_reg <= 6'd0;
    else if (clk_en) cnt_reg <= cnt_next;
  end

  assign masked = (cnt_reg != 6'd0);
endmodule // vmcc_blank_timer
`default_nettype wire

// >>> vmcc_bridge_model.sv
// vmcc_bridge_model: both bridges and coils, seen as one current that follows the coil a high gate
// assumes: gate commands are sampled on the bench clock; sense output is a plain level
`timescale 1ns/10ps
`default_nettype none
module vmcc_bridge_model (
  input  wire logic clock,
  input  wire logic ah,
  input  wire logic al,
  input  wire logic bh,
  input  wire logic bl,
  output var logic  below,
  output var logic  shoot
);
  int cur = 0;
  initial begin
    below = 1'b1;
    shoot = 1'b0;
  end
  // current rises under a high gate and decays slower, so the sense level really toggles
  always @(posedge clock) begin
    cur <= ah ? cur + 3 : (cur > 1 ? cur - 2 : 0);
    below <= cur < 500;
    shoot <= (ah & al) | (bh & bl);
  end
endmodule // vmcc_bridge_model
`default_nettype wire

// >>> voltage_mode_chopper_config_tb.sv
// voltage_mode_chopper_config_tb: registers, mode selection, rates, blank and standstill
// assumes: vmcc_top with a short standby tick and the bridge model on its gates
`timescale 1ns/10ps
`default_nettype none
module voltage_mode_chopper_config_tb;
  import vmcc_pkg::*;
  logic        clock = 0, rst = 1, clk_en = 1, avs_read = 0, avs_write = 0, shoot;
  logic        spread_pin = 0, fullstep_strobe = 0, motor_standstill = 0;
  logic [4:0]  avs_address = 0, run_current = 5'h1f, ra;
  logic [31:0] avs_writedata = 0, avs_readdata, rdata, regs [8];
  logic [3:0]  avs_byteenable = 4'hf;
  logic [19:0] microstep_interval = 20'h100;
  logic        avs_waitrequest, current_low_pin, coil_a_high, coil_a_low, coil_b_high;
  logic        coil_b_low, voltage_mode_active, comparator_masked;
  logic [7:0]  pwm_amplitude, c0;
  logic [1:0]  p;
  int          miscompares = 0, tests_run = 0, seed = 7, n, tick = 0;
  int          per [4] = '{1024, 683, 512, 410};
  int          blk [4] = '{16, 24, 36, 54};
  logic [3:0]  ost [4] = '{4'h0, 4'h0, 4'b0101, 4'b1010};
  logic [31:0] wm [8] = '{32'hfff7, 32'hfffff, 32'hffff, 32'h1f3f, 32'hfff, 0, 0, 0};

  vmcc_top #(.STANDBY_TICK(4)) dut (.clock, .rst, .clk_en, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .spread_pin, .current_low_pin, .microstep_interval, .fullstep_strobe,
    .motor_standstill, .run_current, .coil_a_high, .coil_a_low, .coil_b_high, .coil_b_low,
    .voltage_mode_active, .comparator_masked, .pwm_amplitude);
  vmcc_bridge_model bridges (.clock, .ah(coil_a_high), .al(coil_a_low), .bh(coil_b_high),
    .bl(coil_b_low), .below(current_low_pin), .shoot);

  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    p <= {comparator_masked, coil_a_high};
    tick <= tick + 1;
    fullstep_strobe <= (tick % 40 == 0);
  end

  // ----------------------------------------------------------------
  // checking and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] e);
    tests_run++;
    if (seen !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", s, e, seen);
    end
  endtask
  task automatic conclude();
    if (miscompares == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // request held until waitrequest is sampled low; one idle edge keeps drivers single
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] b);
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) miscompares++;
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic wreg(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
    logic [31:0] lm;
    lm = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}} & wm[a[4:2]];
    bus(1'b1, a, d, b);
    regs[a[4:2]] = (regs[a[4:2]] & ~lm) | (d & lm);
    regs[5] = {8'h0, regs[2][15:0], 8'h0};
  endtask
  // correction and mode bits of the status word move on their own, so they are masked
  task automatic rchk(input logic [4:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
    chk("readdata", rdata & (a == 5'h14 ? 32'h00ffff00 : '1), regs[a[4:2]]);
  endtask
  task automatic vm(input logic e);
    repeat (8) @(posedge clock);
    chk("vmode", voltage_mode_active, e);
  endtask
  task automatic wait_rise(input int m);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (!((m ? comparator_masked : coil_a_high) && !p[m]) && n < 3000);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    regs = '{32'h4c00, 0, 32'h1e, 32'h10, 0, 32'h1e00, 0, 0};
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("waitrequest", avs_waitrequest, 1'b1);
    for (int i = 0; i < 8; i++) rchk(5'(i * 4));
    for (int i = 0; i < 30; i++) begin
      ra = 5'($random(seed)) & 5'h1c;
      wreg(ra, $random(seed) & ~32'h2, 4'($random(seed)));
      rchk(ra);
    end
    wreg(5'h00, 32'hc400, 4'hf);
    wreg(5'h04, 32'h0, 4'hf);
    wreg(5'h08, 32'h80, 4'hf);
    wreg(5'h0c, 32'h1000, 4'hf);
    vm(1'b0);
    chk("gates", {coil_a_high, coil_a_low, coil_b_high, coil_b_low}, 0);
    wreg(5'h0c, 32'h1001, 4'hf);
    vm(1'b1);
    spread_pin <= 1'b1;
    vm(1'b0);
    wreg(5'h00, 32'hc401, 4'hf);
    vm(1'b1);
    clk_en <= 1'b0;
    spread_pin <= 1'b0;
    vm(1'b1);
    clk_en <= 1'b1;
    vm(1'b0);
    wreg(5'h00, 32'hc400, 4'hf);
    wreg(5'h04, 32'd1000, 4'hf);
    microstep_interval <= 20'd999;
    vm(1'b0);
    microstep_interval <= 20'd1000;
    repeat (3) @(posedge clock);
    chk("cap", pwm_amplitude, {4'h4, 4'h0});
    vm(1'b1);
    for (int r = 0; r < 4; r++) begin
      wreg(5'h00, 32'hc400 | (r << 4), 4'hf);
      wreg(5'h0c, 32'h1001 | (r << 4), 4'hf);
      repeat (3) wait_rise(0);
      chk("period", n, per[r]);
      chk("pair", {coil_a_low, coil_b_high}, {!coil_a_high, coil_a_high});
      chk("shoot", shoot, 1'b0);
      chk("amplitude", pwm_amplitude, 128 * 31 / 32);
      wait_rise(1);
      n = 0;
      while (comparator_masked === 1'b1 && n < 100) begin
        @(posedge clock);
        n++;
      end
      chk("blank", n, blk[r]);
    end
    wreg(5'h08, 32'h3000, 4'hf);
    repeat (2) @(posedge clock);
    chk("zero_ofs", pwm_amplitude, 8'h30);
    wreg(5'h10, 32'h0102, 4'hf);
    wreg(5'h0c, 32'h0001, 4'hf);
    for (int o = 1; o < 4; o++) begin
      wreg(5'h00, 32'hc400 | (o << 6), 4'hf);
      motor_standstill <= 1'b1;
      // sampled just before power-down plus hold delay have both run out
      repeat (11) @(posedge clock);
      bus(1'b0, 5'h14, 32'h0, 4'hf);
      chk("early", rdata[25], 1'b0);
      repeat (40) @(posedge clock);
      chk("hold", {coil_a_high, coil_a_low, coil_b_high, coil_b_low}, ost[o]);
      motor_standstill <= 1'b0;
      repeat (4) @(posedge clock);
    end
    // current mode by a high limit: the correction must not move under feedback
    wreg(5'h00, 32'hc402, 4'hf);
    wreg(5'h0c, 32'h1011, 4'hf);
    microstep_interval <= 20'd10;
    // let the last regulator step in voltage mode land before the first read
    repeat (2) @(posedge clock);
    bus(1'b0, 5'h14, 32'h0, 4'hf);
    c0 = rdata[7:0];
    repeat (200) @(posedge clock);
    bus(1'b0, 5'h14, 32'h0, 4'hf);
    chk("frozen", rdata[7:0], c0);
    conclude();
  end
  initial begin
    #400us;
    miscompares++;
    conclude();
  end
endmodule // voltage_mode_chopper_config_tb
`default_nettype wire
